// [hdl/bsc_port.sv]
// Synchronous pipelined burst SRAM: strobe decode, burst counter, array and lanes.
// Assumes all inputs synchronous to mclk; each data and parity pin is split into in and out, with one low-active enable per lane.
//
// Contract
// RULE_01: A low controller address strobe at an edge drops any burst and loads the external address; the code loads it only if selected and unstalled.
// RULE_02: Strobe low with all selects active reads or writes the new address as the write controls say.
// RULE_03: Strobe low with the primary select high enters deselected power-down and drives no data.
// RULE_04: A low burst order select makes the burst counter walk addresses linearly.
// RULE_05: A high burst order select makes the burst counter walk the interleaved sequence.
// RULE_06: The controller keeps the burst order select fixed while the memory operates.
// RULE_07: A high sleep request puts the device into standby and keeps every stored word.
// RULE_08: While sleep is requested every other input is ignored.
// RULE_09: Data is split into byte lanes a and b on the 18-bit build and a to d on the wider builds.
// RULE_10: Write data on the lanes is captured at the rising edge of the write cycle.
// RULE_11: Parity lanes are absent on the 32-bit build and present per lane on the 18 and 36-bit builds.
// RULE_12: Interleaved order flips the two low start bits with 01, 10 and 11 in turn.
// RULE_13: Linear order adds one to the two low bits per advance, wrapping within four words.
// RULE_14: A low burst advance steps the counter, a high one holds the address as a wait state.
// RULE_15: A cycle writes when global write is low or the byte gate and any lane enable are low.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_port #(
    parameter int ADDR_W = `BSC_ADDR_W_DEF,
    parameter int LANES = `BSC_LANES_DEF,
    parameter int PARITY = `BSC_PARITY_DEF
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // Standby request.
    input wire logic sleep_request,
    // Address and burst control.
    input wire logic [ADDR_W-1:0] address,
    input wire logic ctl_addr_strobe_n,
    input wire logic primary_select_n,
    input wire logic second_select_hi,
    input wire logic third_select_n,
    input wire logic burst_advance_n,
    input wire logic burst_order_sel,
    // Write controls.
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [LANES-1:0] lane_write_enable_n,
    // Data and parity lanes.
    input wire logic [LANES*`BSC_LANE_W-1:0] byte_lane_in,
    input wire logic [LANES-1:0] parity_lane_in,
    output logic [LANES*`BSC_LANE_W-1:0] byte_lane_out,
    output logic [LANES-1:0] byte_lane_oe_n,
    output logic [LANES-1:0] parity_lane_out,
    output logic [LANES-1:0] parity_lane_oe_n,
    // Read side flow control and status.
    input wire logic read_ready,
    output logic read_stall,
    output logic power_down,
    output logic sleeping
);
    localparam int WW = LANES * `BSC_SLOT_W;
    localparam int DEPTH = 2 ** ADDR_W;

    generate
        if (ADDR_W < `BSC_BURST_W || !((LANES == 2 && PARITY == 1) || LANES == 4) || PARITY > 1) begin : g_bad
            $error("bsc_port serves x18 (2 lanes, parity), x32 or x36 only");
        end
    endgenerate

    bsc_stream_if #(.W(WW)) push_if ();
    bsc_stream_if #(.W(WW)) pop_if ();

    logic [WW-1:0] mem [DEPTH];
    bsc_pkg::bsc_state_e state, next_state;
    logic [ADDR_W-1:0] base, next_base;
    bsc_pkg::bsc_ofs_t start_ofs, next_start_ofs, cnt, next_cnt, acc_ofs;
    logic [ADDR_W-1:0] acc_addr;
    logic run, start, sel_ok, is_write, access, stall, flush;
    logic [LANES-1:0] lane_we;
    logic [WW-1:0] wr_word;
    logic [LANES*`BSC_LANE_W-1:0] next_lane_out;
    logic [LANES-1:0] next_lane_oe_n, next_par_out, next_par_oe_n;

    // Strobe, select and write decode of the sampled pins.
    assign run = clk_en && !sleep_request; // RULE_08
    assign start = !ctl_addr_strobe_n; // RULE_01
    assign sel_ok = !primary_select_n && second_select_hi && !third_select_n; // RULE_02
    assign is_write = !global_write_n || (!byte_write_gate_n && |(~lane_write_enable_n)); // RULE_15
    assign lane_we = !global_write_n ? {LANES{1'b1}} : (!byte_write_gate_n ? ~lane_write_enable_n : '0); // RULE_15

    // Each lane's slot holds its byte with the parity bit above it.
    always_comb begin
        wr_word = '0;
        for (int i = 0; i < LANES; i++) begin
            wr_word[i*`BSC_SLOT_W +: `BSC_LANE_W] = byte_lane_in[i*`BSC_LANE_W +: `BSC_LANE_W]; // RULE_09
            wr_word[i*`BSC_SLOT_W + `BSC_LANE_W] = (PARITY != 0) ? parity_lane_in[i] : 1'b0; // RULE_11
        end
    end

    // Burst state: load on a selected strobe, step or hold while bursting, freeze in sleep.
    always_comb begin
        next_state = state;
        next_base = base;
        next_start_ofs = start_ofs;
        next_cnt = cnt;
        access = 1'b0;
        flush = 1'b0;
        unique case (state)
            bsc_pkg::BSC_SLEEP: begin
                if (!sleep_request) begin
                    next_state = bsc_pkg::BSC_IDLE;
                end
            end
            bsc_pkg::BSC_IDLE, bsc_pkg::BSC_BURST: begin
                if (sleep_request) begin
                    next_state = bsc_pkg::BSC_SLEEP; // RULE_07
                    flush = 1'b1;
                end else if (start && sel_ok) begin
                    next_state = bsc_pkg::BSC_BURST; // RULE_01
                    next_base = address;
                    next_start_ofs = address[`BSC_BURST_W-1:0];
                    next_cnt = `BSC_CNT_RST;
                    access = 1'b1; // RULE_02
                end else if (start) begin
                    next_state = bsc_pkg::BSC_IDLE; // RULE_03
                    flush = 1'b1;
                end else if (state == bsc_pkg::BSC_BURST) begin
                    if (!burst_advance_n) begin
                        next_cnt = cnt + 2'h1; // RULE_14
                    end
                    access = 1'b1;
                end
            end
            default: begin
                next_state = bsc_pkg::BSC_IDLE;
            end
        endcase
        stall = access && !is_write && !push_if.ready;
        if (stall) begin
            next_state = state;
            next_base = base;
            next_start_ofs = start_ofs;
            next_cnt = cnt;
        end
    end

    // Address of this cycle's access in the selected burst order.
    always_comb begin
        if (burst_order_sel) begin
            acc_ofs = next_start_ofs ^ next_cnt; // RULE_05 RULE_12
        end else begin
            acc_ofs = next_start_ofs + next_cnt; // RULE_04 RULE_13
        end
        acc_addr = {next_base[ADDR_W-1:`BSC_BURST_W], acc_ofs};
    end

    // Read words enter the buffer; a deselect or sleep flushes it.
    assign push_if.valid = run && access && !is_write;
    assign push_if.data = mem[acc_addr];
    assign push_if.flush = clk_en && flush;
    assign pop_if.ready = read_ready && !flush && !sleep_request;

    bsc_skid_buf #(.W(WW), .DEPTH(`BSC_BUF_DEPTH)) u_buf (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .fill(push_if.snk),
        .drain(pop_if.src)
    );

    // Lane drivers: drive a word when one leaves the buffer, otherwise release the pins.
    always_comb begin
        next_lane_out = byte_lane_out;
        next_par_out = parity_lane_out;
        next_lane_oe_n = '1;
        next_par_oe_n = '1;
        if (pop_if.valid && pop_if.ready) begin
            for (int i = 0; i < LANES; i++) begin
                next_lane_out[i*`BSC_LANE_W +: `BSC_LANE_W] = pop_if.data[i*`BSC_SLOT_W +: `BSC_LANE_W]; // RULE_09
                next_par_out[i] = (PARITY != 0) ? pop_if.data[i*`BSC_SLOT_W + `BSC_LANE_W] : 1'b0; // RULE_11
            end
            next_lane_oe_n = '0;
            next_par_oe_n = (PARITY != 0) ? '0 : '1; // RULE_11
        end
    end

    // Register control state and the pin drivers.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= bsc_pkg::BSC_IDLE;
            base <= '0;
            start_ofs <= `BSC_OFS_RST;
            cnt <= `BSC_CNT_RST;
            byte_lane_out <= '0;
            byte_lane_oe_n <= '1;
            parity_lane_out <= '0;
            parity_lane_oe_n <= '1;
            read_stall <= 1'b0;
            power_down <= 1'b1;
            sleeping <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            base <= next_base;
            start_ofs <= next_start_ofs;
            cnt <= next_cnt;
            byte_lane_out <= next_lane_out;
            byte_lane_oe_n <= next_lane_oe_n;
            parity_lane_out <= next_par_out;
            parity_lane_oe_n <= next_par_oe_n;
            read_stall <= run && stall;
            power_down <= (next_state != bsc_pkg::BSC_BURST);
            sleeping <= (next_state == bsc_pkg::BSC_SLEEP);
        end
    end

    // Array write with lane mask at the write cycle's edge; the array is never cleared.
    always_ff @(posedge mclk) begin
        if (run && access && is_write) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_we[i]) begin
                    mem[acc_addr][i*`BSC_SLOT_W +: `BSC_SLOT_W] <= wr_word[i*`BSC_SLOT_W +: `BSC_SLOT_W]; // RULE_10
                end
            end
        end
    end

    // Checks on the port behaviour.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_sel_start;
        run && start && sel_ok && !stall;
    endsequence
    sequence s_burst_loaded;
        state == bsc_pkg::BSC_BURST && cnt == 2'h0;
    endsequence
    sequence s_continue;
        run && state == bsc_pkg::BSC_BURST && !start && !stall;
    endsequence

    property p_start_load;
        s_sel_start |=> s_burst_loaded ##0 (base == $past(address));
    endproperty
    a_start_load: assert property (p_start_load) else $error("strobe did not load a new burst"); // RULE_01

    property p_write_global;
        run && access && !global_write_n |=> mem[$past(acc_addr)] == $past(wr_word);
    endproperty
    a_write_global: assert property (p_write_global) else $error("global write did not store the word"); // RULE_02

    property p_deselect;
        run && start && !sel_ok |=> power_down && (&byte_lane_oe_n) ##1 (&byte_lane_oe_n);
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect left data driven"); // RULE_03

    property p_linear;
        s_continue ##0 !burst_order_sel |-> acc_addr[1:0] == 2'(start_ofs + cnt + {1'b0, !burst_advance_n});
    endproperty
    a_linear: assert property (p_linear) else $error("linear burst address wrong"); // RULE_04

    property p_interleave;
        s_continue ##0 burst_order_sel ##0 !burst_advance_n |-> acc_addr[1:0] == (start_ofs ^ 2'(cnt + 2'h1));
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleaved burst address wrong"); // RULE_05

    property p_hold;
        s_continue ##0 burst_advance_n |=> $stable(cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without advance"); // RULE_14

    property p_sleep;
        clk_en && sleep_request |=> sleeping && (&byte_lane_oe_n);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered"); // RULE_07

    property p_sleep_frozen;
        state == bsc_pkg::BSC_SLEEP && sleep_request |=> $stable(base) && $stable(cnt) && sleeping;
    endproperty
    a_sleep_frozen: assert property (p_sleep_frozen) else $error("state changed in sleep"); // RULE_08

    property p_wake;
        clk_en && state == bsc_pkg::BSC_SLEEP && !sleep_request |=> !sleeping && power_down;
    endproperty
    a_wake: assert property (p_wake) else $error("standby not left after the request dropped"); // RULE_07

    property p_stall_hold;
        run && access && !is_write && !push_if.ready |=> read_stall && $stable(cnt) && $stable(base);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("refused read cycle moved the burst"); // RULE_02

    sequence s_lane_a_write;
        run && access && global_write_n && !byte_write_gate_n && !lane_write_enable_n[0];
    endsequence
    property p_lane_write;
        s_lane_a_write |=> mem[$past(acc_addr)][`BSC_LANE_W-1:0] == $past(byte_lane_in[`BSC_LANE_W-1:0]);
    endproperty
    a_lane_write: assert property (p_lane_write) else $error("lane write did not store its byte"); // RULE_15

    property p_parity_absent;
        (PARITY == 0) |-> (&parity_lane_oe_n) && parity_lane_out == '0;
    endproperty
    a_parity_absent: assert property (p_parity_absent) else $error("parity driven on a build without it"); // RULE_11

endmodule : bsc_port

`default_nettype wire

// [hdl/bsc_skid_buf.sv]
// Two-entry word buffer with valid/ready on both sides and a flush.
// Assumes one clock; a low clock enable freezes every flip-flop.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_skid_buf #(
    parameter int W = 36,
    parameter int DEPTH = `BSC_BUF_DEPTH
) (
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // Filling side and draining side.
    bsc_stream_if.snk fill,
    bsc_stream_if.src drain
);
    generate
        if (DEPTH != 2) begin : g_bad_depth
            $error("bsc_skid_buf serves a depth of two only");
        end
    endgenerate

    logic [W-1:0] slot [DEPTH];
    logic [W-1:0] next_slot [DEPTH];
    logic wr_idx, rd_idx, next_wr_idx, next_rd_idx;
    logic [1:0] count, next_count;
    logic push, pop;

    // Ready and valid come straight from the fill count.
    assign fill.ready = (count != 2'h2);
    assign drain.valid = (count != 2'h0);
    assign drain.data = slot[rd_idx];
    assign drain.flush = 1'b0;
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // Next pointers, count and contents; a flush drops every entry.
    always_comb begin
        next_slot = slot;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_count = count;
        if (fill.flush) begin
            next_wr_idx = 1'b0;
            next_rd_idx = 1'b0;
            next_count = 2'h0;
        end else begin
            if (push) begin
                next_slot[wr_idx] = fill.data;
                next_wr_idx = !wr_idx;
            end
            if (pop) begin
                next_rd_idx = !rd_idx;
            end
            next_count = count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Register the buffer state.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= 2'h0;
        end else if (clk_en) begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            count <= next_count;
        end
    end

    // Entry storage carries no reset; the count says which entries hold data.
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            slot <= next_slot;
        end
    end

endmodule : bsc_skid_buf

`default_nettype wire

// [shared/bsc_pkg.sv]
// Types shared by the burst SRAM port modules.
// Assumes bsc_regs.svh is on the include path.
`include "bsc_regs.svh"

package bsc_pkg;

    // Operating state of the port.
    typedef enum logic [1:0] {
        BSC_IDLE,
        BSC_BURST,
        BSC_SLEEP
    } bsc_state_e;

    // Low address bits walked by the burst counter.
    typedef logic [`BSC_BURST_W-1:0] bsc_ofs_t;

endpackage : bsc_pkg

// [shared/bsc_regs.svh]
// Constants for the burst SRAM port: widths, burst step and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// Bits of data in one byte lane and bits held per lane (data plus parity slot).
`define BSC_LANE_W 8
`define BSC_SLOT_W 9
// Width of the burst counter; a burst covers four words.
`define BSC_BURST_W 2
// Default geometry: 32K words of four lanes with parity.
`define BSC_ADDR_W_DEF 15
`define BSC_LANES_DEF 4
`define BSC_PARITY_DEF 1
// Entries of the read buffer.
`define BSC_BUF_DEPTH 2
// Reset values of the burst counter and start offset.
`define BSC_CNT_RST 2'h0
`define BSC_OFS_RST 2'h0

`endif

// [shared/bsc_stream_if.sv]
// Valid/ready word stream between the port logic and its read buffer.
// Assumes one clock shared by both ends; flush empties the receiver.
`timescale 1ns/1ps
`default_nettype none

interface bsc_stream_if #(
    parameter int W = 36
);
    logic valid;
    logic ready;
    logic flush;
    logic [W-1:0] data;

    // Producer side.
    modport src (output valid, output data, output flush, input ready);
    // Consumer side.
    modport snk (input valid, input data, input flush, output ready);
endinterface : bsc_stream_if

`default_nettype wire

// [verification/bsc_host_model.sv]
// Host controller model: drives the port's pins one bus cycle at a time.
// Assumes the bench calls its tasks 1 ns after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none

module bsc_host_model (
    // Clock.
    input wire logic mclk,
    // Control pins toward the port.
    output logic sleep_request,
    output logic [14:0] address,
    output logic ctl_addr_strobe_n,
    output logic primary_select_n,
    output logic burst_advance_n,
    output logic burst_order_sel,
    output logic global_write_n,
    output logic byte_write_gate_n,
    output logic [3:0] lane_write_enable_n,
    output logic read_ready,
    // Data and parity wires as {parity, data}, with their low-active enables.
    output logic [35:0] lane_in,
    input wire logic [35:0] lane_out,
    input wire logic [7:0] lane_oe_n
);
    logic [35:0] host_word;
    logic host_drives;

    // A wire shows the port's bit while it drives, the host word during a write, else its inverse.
    always_comb begin
        for (int i = 0; i < 36; i++) begin
            if (!lane_oe_n[i < 32 ? i / 8 : i - 28]) lane_in[i] = lane_out[i];
            else lane_in[i] = host_drives ? host_word[i] : ~host_word[i];
        end
    end

    // Pins idle at time zero: deselected, no write, receiver ready.
    initial begin
        sleep_request = 1'b0;
        address = 15'h0;
        ctl_addr_strobe_n = 1'b1;
        primary_select_n = 1'b1;
        burst_advance_n = 1'b1;
        burst_order_sel = 1'b0;
        global_write_n = 1'b1;
        byte_write_gate_n = 1'b1;
        lane_write_enable_n = 4'hf;
        read_ready = 1'b1;
        host_word = 36'h0;
        host_drives = 1'b0;
    end

    // Sets the held levels; the bench changes the order select only while deselected.
    task automatic set_levels(input logic sleep, input logic ready, input logic order);
        sleep_request = sleep;
        read_ready = ready;
        burst_order_sel = order;
    endtask : set_levels

    // One bus cycle: drive strobe, select, advance, address, write and data pins, then hold them until the next rising edge has taken them.
    task automatic cyc(input logic strobe_n, input logic sel_n, input logic adv_n, input logic [14:0] a,
                       input logic [1:0] wr, input logic [3:0] lanes_n, input logic [35:0] w);
        ctl_addr_strobe_n = strobe_n;
        primary_select_n = sel_n;
        burst_advance_n = adv_n;
        address = a;
        {global_write_n, byte_write_gate_n} = wr;
        lane_write_enable_n = lanes_n;
        host_word = w;
        host_drives = !wr[1] || (!wr[0] && lanes_n != 4'hf);
        @(posedge mclk);
        #1;
    endtask : cyc
endmodule : bsc_host_model

`default_nettype wire

// [verification/burst_sram_ctl_port_tb_top.sv]
// Self-checking bench for the burst SRAM port with a host controller model on its pins.
// Assumes the four-lane build with parity and a 15-bit word address.
`timescale 1ns/1ps
`default_nettype none

module burst_sram_ctl_port_tb_top;
    // One burst of four accesses: start, order, write controls, wait mask and first word.
    typedef struct {
        logic [14:0] addr;
        logic ord;
        logic [1:0] wr;
        logic [3:0] lanes_n;
        logic [3:0] hold;
        logic [35:0] data;
    } bsc_row_s;

    logic mclk, reset, clk_en, read_stall, power_down, sleeping;
    logic sleep_request, ctl_addr_strobe_n, primary_select_n, burst_advance_n, burst_order_sel;
    logic global_write_n, byte_write_gate_n, read_ready, sel2_hi, sel3_n;
    logic [14:0] address;
    logic [3:0] lane_write_enable_n;
    logic [35:0] lane_in;
    wire [35:0] lane_out;
    wire [7:0] lane_oe_n;
    int failures, n_checks;
    logic [35:0] exp_mem [logic [14:0]];
    logic [35:0] pend [$];
    bsc_row_s rows [8] = '{
        '{15'h0011, 1'b0, 2'h1, 4'hf, 4'h0, 36'h9a1b2c3d4},
        '{15'h0011, 1'b0, 2'h3, 4'hf, 4'h0, 36'h0},
        '{15'h0013, 1'b1, 2'h3, 4'hf, 4'h0, 36'h0},
        '{15'h0012, 1'b1, 2'h2, 4'ha, 4'h4, 36'h5f00e1177},
        '{15'h0012, 1'b1, 2'h2, 4'hf, 4'h2, 36'h0},
        '{15'h0010, 1'b0, 2'h3, 4'h0, 4'h0, 36'h0},
        '{15'h0027, 1'b0, 2'h1, 4'hf, 4'h0, 36'h3c0de0042},
        '{15'h0024, 1'b0, 2'h3, 4'hf, 4'h0, 36'h0}};

    bsc_port #(.ADDR_W(15), .LANES(4), .PARITY(1)) uut (
        .mclk(mclk), .reset(reset), .clk_en(clk_en), .sleep_request(sleep_request), .address(address),
        .ctl_addr_strobe_n(ctl_addr_strobe_n), .primary_select_n(primary_select_n), .second_select_hi(sel2_hi),
        .third_select_n(sel3_n), .burst_advance_n(burst_advance_n), .burst_order_sel(burst_order_sel),
        .global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
        .lane_write_enable_n(lane_write_enable_n), .byte_lane_in(lane_in[31:0]), .parity_lane_in(lane_in[35:32]),
        .byte_lane_out(lane_out[31:0]), .byte_lane_oe_n(lane_oe_n[3:0]), .parity_lane_out(lane_out[35:32]),
        .parity_lane_oe_n(lane_oe_n[7:4]), .read_ready(read_ready), .read_stall(read_stall),
        .power_down(power_down), .sleeping(sleeping));

    bsc_host_model host (
        .mclk(mclk), .sleep_request(sleep_request), .address(address), .ctl_addr_strobe_n(ctl_addr_strobe_n),
        .primary_select_n(primary_select_n), .burst_advance_n(burst_advance_n), .burst_order_sel(burst_order_sel),
        .global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
        .lane_write_enable_n(lane_write_enable_n), .read_ready(read_ready), .lane_in(lane_in),
        .lane_out(lane_out), .lane_oe_n(lane_oe_n));

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [43:0] seen, input logic [43:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Compares the word on the lanes now with the oldest expected read word.
    task automatic check_word();
        check("read word", {lane_oe_n, lane_out}, {8'h0, pend.pop_front()});
    endtask : check_word

    // Merges a written word lane by lane, each parity bit following its lane.
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] w, input logic [1:0] wr,
                                          input logic [3:0] lanes_n);
        logic [35:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (!wr[1] || !lanes_n[i]) begin
                m[i*8 +: 8] = w[i*8 +: 8];
                m[32+i] = w[32+i];
            end
        end
        return m;
    endfunction : merge

    // Deselects, lets one idle cycle pass and expects released lanes and power-down.
    task automatic end_burst();
        host.cyc(1'b0, 1'b1, 1'b1, 15'h0, 2'h3, 4'hf, 36'h0);
        host.cyc(1'b1, 1'b1, 1'b1, 15'h0, 2'h3, 4'hf, 36'h0);
        check("released", {35'h0, lane_oe_n, power_down}, {35'h0, 8'hff, 1'b1});
        pend.delete();
    endtask : end_burst

    // Runs one four-access burst and checks each read word one cycle after its access.
    task automatic run_row(input bsc_row_s r);
        logic [1:0] n;
        logic [14:0] ea;
        logic is_wr;
        n = 2'h0;
        is_wr = !r.wr[1] || (!r.wr[0] && r.lanes_n != 4'hf);
        host.set_levels(1'b0, 1'b1, r.ord);
        for (int k = 0; k < 4; k++) begin
            if (k > 0 && !r.hold[k]) n = n + 2'h1;
            ea = r.ord ? {r.addr[14:2], r.addr[1:0] ^ n} : {r.addr[14:2], r.addr[1:0] + n};
            if (is_wr) exp_mem[ea] = merge(exp_mem[ea], r.data + 36'(k), r.wr, r.lanes_n);
            else pend.push_back(exp_mem[ea]);
            host.cyc(k > 0, 1'b0, r.hold[k], r.addr, r.wr, r.lanes_n, r.data + 36'(k));
            if (k > 0 && !is_wr) check_word();
        end
        if (!is_wr) begin
            host.cyc(1'b1, 1'b0, 1'b1, r.addr, 2'h3, 4'hf, 36'h0);
            check_word();
        end
        end_burst();
    endtask : run_row

    // Free-running 25 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Cuts a hung run short after far more cycles than the tests need.
    initial begin
        repeat (2000) @(posedge mclk);
        failures++;
        wrap_up();
    end

    // Reset, table of bursts, then sleep, restart mid-burst and a full buffer.
    initial begin
        failures = 0;
        n_checks = 0;
        reset = 1'b1;
        clk_en = 1'b1;
        sel2_hi = 1'b1;
        sel3_n = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        check("reset", {33'h0, lane_oe_n, power_down, sleeping, read_stall}, {33'h0, 8'hff, 3'h4});
        $display("reset test done");
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        host.set_levels(1'b1, 1'b1, 1'b0);
        host.cyc(1'b0, 1'b0, 1'b1, 15'h0011, 2'h1, 4'hf, 36'h0);
        check("sleep", {35'h0, lane_oe_n, sleeping}, {35'h0, 8'hff, 1'b1});
        host.set_levels(1'b0, 1'b1, 1'b0);
        host.cyc(1'b1, 1'b1, 1'b1, 15'h0, 2'h3, 4'hf, 36'h0);
        check("wake", {43'h0, sleeping}, 44'h0);
        run_row(rows[1]);
        $display("sleep test done");
        pend.push_back(exp_mem[15'h0010]);
        host.cyc(1'b0, 1'b0, 1'b1, 15'h0010, 2'h3, 4'hf, 36'h0);
        pend.push_back(exp_mem[15'h0013]);
        host.cyc(1'b0, 1'b0, 1'b0, 15'h0013, 2'h3, 4'hf, 36'h0);
        check_word();
        pend.push_back(exp_mem[15'h0010]);
        host.cyc(1'b1, 1'b0, 1'b0, 15'h0013, 2'h3, 4'hf, 36'h0);
        check_word();
        host.cyc(1'b1, 1'b0, 1'b1, 15'h0013, 2'h3, 4'hf, 36'h0);
        check_word();
        end_burst();
        $display("restart test done");
        host.set_levels(1'b0, 1'b0, 1'b0);
        host.cyc(1'b0, 1'b0, 1'b1, 15'h0024, 2'h3, 4'hf, 36'h0);
        host.cyc(1'b1, 1'b0, 1'b0, 15'h0024, 2'h3, 4'hf, 36'h0);
        host.cyc(1'b1, 1'b0, 1'b0, 15'h0024, 2'h3, 4'hf, 36'h0);
        check("stall", {43'h0, read_stall}, 44'h1);
        host.set_levels(1'b0, 1'b1, 1'b0);
        pend.push_back(exp_mem[15'h0024]);
        pend.push_back(exp_mem[15'h0025]);
        host.cyc(1'b1, 1'b0, 1'b0, 15'h0024, 2'h3, 4'hf, 36'h0);
        check_word();
        host.cyc(1'b1, 1'b0, 1'b1, 15'h0024, 2'h3, 4'hf, 36'h0);
        check_word();
        end_burst();
        $display("full buffer test done");
        sel2_hi = 1'b0;
        host.cyc(1'b0, 1'b0, 1'b1, 15'h0010, 2'h3, 4'hf, 36'h0);
        check("second select", {35'h0, lane_oe_n, power_down}, {35'h0, 8'hff, 1'b1});
        sel2_hi = 1'b1;
        sel3_n = 1'b1;
        host.cyc(1'b0, 1'b0, 1'b1, 15'h0010, 2'h3, 4'hf, 36'h0);
        check("third select", {35'h0, lane_oe_n, power_down}, {35'h0, 8'hff, 1'b1});
        sel3_n = 1'b0;
        $display("select test done");
        wrap_up();
    end
endmodule : burst_sram_ctl_port_tb_top

`default_nettype wire
